// >>> rtl/aed_consts.svh
// Register offsets, field positions, reset values and timing counts of the energy datapath.
`ifndef AED_CONSTS_SVH
`define AED_CONSTS_SVH

// Register port addresses (6-bit register index).
`define AED_ADDR_PHASE      6'h01
`define AED_ADDR_GAIN       6'h02
`define AED_ADDR_OFFSET     6'h03
`define AED_ADDR_DIVIDER    6'h04
`define AED_ADDR_ENERGY     6'h05
`define AED_ADDR_ENERGY_CLR 6'h06
`define AED_ADDR_MODE       6'h07
`define AED_ADDR_IRQ_EN     6'h08
`define AED_ADDR_STATUS     6'h09
`define AED_ADDR_STATUS_CLR 6'h0a
`define AED_ADDR_WAVE       6'h0b

// Reset values.
`define AED_RST_PHASE       6'h0d
`define AED_RST_GAIN        12'h000
`define AED_RST_OFFSET      16'h0000
`define AED_RST_DIVIDER     8'h00
`define AED_RST_MODE        16'h0000
`define AED_RST_IRQ_EN      16'h0000

// Field positions.
`define AED_MODE_RATE_LO    11
`define AED_MODE_SRC_LO     13
`define AED_IRQ_HALF        0
`define AED_IRQ_OVF         1
`define AED_IRQ_WAVEFORM_SAMPLE_ENABLE        3

// Phase calibration codes.
`define AED_PHASE_ILLEGAL   6'h20
`define AED_PHASE_MIN       6'h21
`define AED_PHASE_BIAS      6'h1f
`define AED_PHASE_ZERO_TAP  44
`define AED_PHASE_TAPS      63

// Timing.
`define AED_CLK_NS          8
`define AED_ACC_DIV         4
`define AED_PHASE_STEP_NS   2220
`define AED_PHASE_STEP_CYC  (`AED_PHASE_STEP_NS / `AED_CLK_NS)
`define AED_WAVE_PERIOD_NS  35760
`define AED_WAVE_BASE_CYC   (`AED_WAVE_PERIOD_NS / `AED_CLK_NS)
`define AED_LPF_SHIFT       8

`endif

// >>> rtl/aed_pkg.sv
// Types shared by the energy datapath and its register port.
package aed_pkg;

  // One register access from the serial interface logic.
  typedef struct packed {
    logic        wr;     // One-cycle write strobe.
    logic        rd;     // One-cycle read strobe.
    logic [5:0]  addr;   // Register index.
    logic [23:0] wdata;  // Write data, right justified.
  } aed_reg_req_s;

  // Read answer returned one cycle after the read strobe.
  typedef struct packed {
    logic        valid;  // One-cycle pulse.
    logic [23:0] data;   // Read data, right justified.
  } aed_reg_rsp_s;

  // Waveform source selections of the mode register.
  typedef enum logic [1:0] {
    AED_SRC_POWER = 2'h0,
    AED_SRC_OTHER = 2'h1,
    AED_SRC_CH1   = 2'h2,
    AED_SRC_CH2   = 2'h3
  } aed_wave_src_e;

  typedef logic signed [47:0] aed_wide_t;

endpackage

// >>> rtl/aed_datapath.sv
// Active power and energy datapath with phase, gain, offset and divider calibration.
`timescale 1ns/1ps
`include "aed_consts.svh"

// Operation
// RULE_01: Phase code is 6-bit signed, 21h..1Fh.
// RULE_02: Code 0Dh means zero added delay.
// RULE_03: Each phase step shifts by 2.22 us.
// RULE_04: Shift only voltage path, -97.68..+39.96 us.
// RULE_05: Multiply samples, low-pass to active power.
// RULE_06: Scale power by one plus gain/4096.
// RULE_07: Add signed offset, 256 counts per LSB.
// RULE_08: Divide by 8-bit divider, zero means one.
// RULE_09: Accumulate into 48 bits every 4 clocks.
// RULE_10: Accumulation is signed; negative power subtracts.
// RULE_11: Energy read returns upper 24 bits, unchanged.
// RULE_12: Clearing read returns value, clears upper bits.
// RULE_13: Accumulator wraps on overflow and underflow.
// RULE_14: Enabled half-full and overflow events raise interrupt.
// RULE_15: Source 00 plus bit 3 streams power.
// RULE_16: Four waveform rates, 27.9k down to 3.5k.
// RULE_17: Fill time grows in proportion to divider.
// RULE_18: Mode bits 12:11 select waveform rate.
// RULE_19: Interrupt holds until clearing status read.
// RULE_20: New calibration applies at next datapath sample.
module aed_datapath #(
  parameter int unsigned WAVE_BASE_CYC = `AED_WAVE_BASE_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic signed [23:0]   currentSample,
  input  wire logic signed [23:0]   voltageSample,
  input  wire aed_pkg::aed_reg_req_s regReq,
  output aed_pkg::aed_reg_rsp_s     regRsp_r,
  output logic [23:0]               waveSample_r,
  output logic                      waveStrobe_r,
  output logic                      irqN_r
);
  import aed_pkg::*;

  // Host-written settings.
  logic [5:0]         phase_r;         // Phase calibration code.
  logic [11:0]        gain_r;          // Power gain code.
  logic [15:0]        offset_r;        // Power offset code.
  logic [7:0]         divider_r;       // Energy divider.
  logic [15:0]        mode_r;          // Mode register.
  logic [15:0]        irqEn_r;         // Interrupt enables.
  // Working copies taken at datapath sample ticks.
  logic [5:0]         phaseAct_r;      // Phase code in use.
  logic signed [11:0] gainAct_r;       // Gain code in use.
  logic signed [15:0] offsetAct_r;     // Offset code in use.
  logic [7:0]         divAct_r;        // Divider in use.
  // Datapath state.
  logic [1:0]         accCnt_r;        // Divides the clock down to the accumulation rate.
  logic               accTick;         // One-cycle accumulation enable.
  logic [8:0]         stepCnt_r;       // Divides the clock down to the phase step rate.
  logic               stepTick;        // One-cycle phase step enable.
  logic signed [23:0] vLine_r [0:`AED_PHASE_TAPS-1]; // Voltage delay line.
  logic signed [23:0] iLine_r [0:`AED_PHASE_ZERO_TAP-1]; // Current delay line.
  logic [5:0]         vTap;            // Voltage tap picked by the phase code.
  logic signed [23:0] vDel;            // Time-shifted voltage sample.
  logic signed [23:0] iDel;            // Aligned current sample.
  aed_wide_t          instPower;       // Instantaneous power.
  aed_wide_t          lp_r;            // Low-pass filter state.
  aed_wide_t          lp_nxt;          // Next filter state.
  aed_wide_t          fine;            // Active power with 8 fraction bits.
  logic signed [59:0] gainProd;        // Power times gain code.
  aed_wide_t          gained;          // Gain-corrected power.
  aed_wide_t          cal;             // Offset-corrected power.
  aed_wide_t          divisor;         // Effective divider as a signed value.
  aed_wide_t          quotient;        // Divided power.
  aed_wide_t          acc_r;           // Energy accumulator.
  aed_wide_t          acc_nxt;         // Next accumulator value.
  aed_wide_t          accBase;         // Accumulator after any clearing read.
  logic               halfNow;         // Readout is at or past half scale.
  logic               halfPrev_r;      // Half-scale state at the last tick.
  logic               ovfEvent;        // Accumulator wrapped this tick.
  logic               halfEvent;       // Readout crossed into half scale.
  logic [15:0]        waveCnt_r;       // Waveform sample period counter.
  logic [15:0]        waveLimit;       // Period for the selected rate.
  logic               waveTick;        // One-cycle waveform sample enable.
  logic               waveOn;          // Active-power streaming enabled.
  logic [15:0]        status_r;        // Sticky event flags.
  logic [15:0]        statusSet;       // Flags raised this cycle.
  logic               rdEnergyClr;     // Clearing energy read this cycle.
  logic               rdStatusClr;     // Clearing status read this cycle.

  assign rdEnergyClr = regReq.rd && (regReq.addr == `AED_ADDR_ENERGY_CLR);
  assign rdStatusClr = regReq.rd && (regReq.addr == `AED_ADDR_STATUS_CLR);

  // Host writes. Code 20h is outside the legal span and is pinned to the most negative step.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_r   <= `AED_RST_PHASE;
      gain_r    <= `AED_RST_GAIN;
      offset_r  <= `AED_RST_OFFSET;
      divider_r <= `AED_RST_DIVIDER;
      mode_r    <= `AED_RST_MODE;
      irqEn_r   <= `AED_RST_IRQ_EN;
    end else if (regReq.wr) begin
      unique case (regReq.addr)
        `AED_ADDR_PHASE: begin
          if (regReq.wdata[5:0] == `AED_PHASE_ILLEGAL) begin
            phase_r <= `AED_PHASE_MIN; // RULE_01
          end else begin
            phase_r <= regReq.wdata[5:0]; // RULE_01
          end
        end
        `AED_ADDR_GAIN:    gain_r    <= regReq.wdata[11:0];
        `AED_ADDR_OFFSET:  offset_r  <= regReq.wdata[15:0];
        `AED_ADDR_DIVIDER: divider_r <= regReq.wdata[7:0];
        `AED_ADDR_MODE:    mode_r    <= regReq.wdata[15:0]; // RULE_18
        `AED_ADDR_IRQ_EN:  irqEn_r   <= regReq.wdata[15:0];
        default: begin
          // Writes to read-only or unmapped addresses are ignored.
        end
      endcase
    end
  end

  // Accumulation rate divider: one tick in every four clocks.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      accCnt_r <= 2'h0;
    end else begin
      accCnt_r <= accCnt_r + 2'h1; // RULE_09
    end
  end
  assign accTick = (accCnt_r == 2'(`AED_ACC_DIV - 1));

  // Calibration settings move into the datapath only on a tick, so a write never lands mid-computation.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phaseAct_r  <= `AED_RST_PHASE;
      gainAct_r   <= `AED_RST_GAIN;
      offsetAct_r <= `AED_RST_OFFSET;
      divAct_r    <= `AED_RST_DIVIDER;
    end else if (accTick) begin
      phaseAct_r  <= phase_r; // RULE_20
      gainAct_r   <= gain_r; // RULE_20
      offsetAct_r <= offset_r; // RULE_20
      divAct_r    <= divider_r; // RULE_20
    end
  end

  // Phase step rate divider; one step is the time resolution of the voltage shift.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stepCnt_r <= 9'h000;
    end else if (stepTick) begin
      stepCnt_r <= 9'h000;
    end else begin
      stepCnt_r <= stepCnt_r + 9'h001;
    end
  end
  assign stepTick = (stepCnt_r == 9'(`AED_PHASE_STEP_CYC - 1)); // RULE_03

  // Delay lines. The current path has a fixed delay equal to the zero tap, so that
  // voltage taps below it give an advance and taps above it a delay. The lines
  // are not reset: their contents are data, and they refill within one span.
  always_ff @(posedge clk) begin
    if (stepTick) begin
      vLine_r[0] <= voltageSample;
      iLine_r[0] <= currentSample;
      for (int k = 1; k < `AED_PHASE_TAPS; k++) begin
        vLine_r[k] <= vLine_r[k-1]; // RULE_04
      end
      for (int k = 1; k < `AED_PHASE_ZERO_TAP; k++) begin
        iLine_r[k] <= iLine_r[k-1];
      end
    end
  end

  // Code 21h maps to tap 0 and 1Fh to tap 62; 0Dh lands on the zero tap.
  assign vTap = phaseAct_r + `AED_PHASE_BIAS; // RULE_02
  assign vDel = vLine_r[vTap]; // RULE_04
  assign iDel = iLine_r[`AED_PHASE_ZERO_TAP-1];

  // Multiplier and first-order low-pass that keeps the DC part of the product.
  assign instPower = iDel * vDel; // RULE_05
  assign lp_nxt = lp_r + ((instPower - lp_r) >>> `AED_LPF_SHIFT); // RULE_05

  always_ff @(posedge clk) begin
    if (!resetn) begin
      lp_r <= 48'sh0;
    end else if (accTick) begin
      lp_r <= lp_nxt; // RULE_05
    end
  end

  // Calibration chain. The filter output is held with 8 fraction bits so that the
  // offset resolves one 256th of a waveform step.
  assign fine     = lp_r >>> 16;
  assign gainProd = fine * gainAct_r; // RULE_06
  assign gained   = fine + 48'(gainProd >>> 12); // RULE_06
  assign cal      = gained + {{32{offsetAct_r[15]}}, offsetAct_r}; // RULE_07

  // A zero divider counts as one; dividing slows the fill by the divider ratio.
  assign divisor  = (divAct_r == 8'h00) ? 48'sh1 : $signed({40'h0, divAct_r}); // RULE_08
  assign quotient = cal / divisor; // RULE_17

  // Clearing read drops the readable upper half while keeping the fraction below it.
  assign accBase = rdEnergyClr ? {24'h0, acc_r[23:0]} : acc_r; // RULE_12
  assign acc_nxt = accBase + quotient; // RULE_10 RULE_13

  // Signed wrap: both operands share a sign and the sum does not.
  assign ovfEvent  = accTick && (accBase[47] == quotient[47]) && (acc_nxt[47] != accBase[47]);
  assign halfNow   = acc_nxt[47] ^ acc_nxt[46];
  assign halfEvent = accTick && halfNow && !halfPrev_r;

  // Accumulator. A clearing read in a non-tick cycle still clears the upper half.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc_r <= 48'sh0;
    end else if (accTick) begin
      acc_r <= acc_nxt; // RULE_09 RULE_13
    end else if (rdEnergyClr) begin
      acc_r <= accBase; // RULE_12
    end
  end

  // Half-scale edge tracker, so the event fires once per crossing.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      halfPrev_r <= 1'b0;
    end else if (accTick) begin
      halfPrev_r <= halfNow; // RULE_14
    end else if (rdEnergyClr) begin
      halfPrev_r <= 1'b0;
    end
  end

  // Waveform rate: the base period doubles for each step of the rate field.
  assign waveLimit = 16'(WAVE_BASE_CYC << mode_r[`AED_MODE_RATE_LO +: 2]); // RULE_16 RULE_18
  assign waveTick  = (waveCnt_r >= waveLimit - 16'h0001);
  assign waveOn    = (aed_wave_src_e'(mode_r[`AED_MODE_SRC_LO +: 2]) == AED_SRC_POWER)
                     && irqEn_r[`AED_IRQ_WAVEFORM_SAMPLE_ENABLE]; // RULE_15

  always_ff @(posedge clk) begin
    if (!resetn) begin
      waveCnt_r <= 16'h0000;
    end else if (waveTick) begin
      waveCnt_r <= 16'h0000;
    end else begin
      waveCnt_r <= waveCnt_r + 16'h0001;
    end
  end

  // Waveform output: a 24-bit active power sample and a strobe per sample period.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      waveSample_r <= 24'h000000;
      waveStrobe_r <= 1'b0;
    end else begin
      waveStrobe_r <= waveTick && waveOn; // RULE_15
      if (waveTick && waveOn) begin
        waveSample_r <= cal[31:8]; // RULE_07 RULE_15
      end
    end
  end

  // Event flags. Of the four streaming sources only active power (source 00) raises a flag here.
  always_comb begin
    statusSet = 16'h0000;
    statusSet[`AED_IRQ_HALF] = halfEvent; // RULE_14
    statusSet[`AED_IRQ_OVF]  = ovfEvent; // RULE_14
    statusSet[`AED_IRQ_WAVEFORM_SAMPLE_ENABLE] = waveTick && waveOn;
  end

  // Sticky status. A flag raised in the cycle of the clearing read survives it.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      status_r <= 16'h0000;
    end else if (rdStatusClr) begin
      status_r <= statusSet; // RULE_19
    end else begin
      status_r <= status_r | statusSet;
    end
  end

  // Interrupt line, low while any enabled flag is pending.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      irqN_r <= 1'b1;
    end else begin
      irqN_r <= ~|((rdStatusClr ? statusSet : (status_r | statusSet)) & irqEn_r); // RULE_14 RULE_19
    end
  end

  // Read answers, one cycle after the strobe. Unmapped addresses read as zero.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      regRsp_r <= '0;
    end else begin
      regRsp_r.valid <= regReq.rd;
      if (regReq.rd) begin
        unique case (regReq.addr)
          `AED_ADDR_PHASE:      regRsp_r.data <= {18'h0, phase_r};
          `AED_ADDR_GAIN:       regRsp_r.data <= {12'h0, gain_r};
          `AED_ADDR_OFFSET:     regRsp_r.data <= {8'h0, offset_r};
          `AED_ADDR_DIVIDER:    regRsp_r.data <= {16'h0, divider_r};
          `AED_ADDR_ENERGY:     regRsp_r.data <= acc_r[47:24]; // RULE_11
          `AED_ADDR_ENERGY_CLR: regRsp_r.data <= acc_r[47:24]; // RULE_12
          `AED_ADDR_MODE:       regRsp_r.data <= {8'h0, mode_r};
          `AED_ADDR_IRQ_EN:     regRsp_r.data <= {8'h0, irqEn_r};
          `AED_ADDR_STATUS:     regRsp_r.data <= {8'h0, status_r};
          `AED_ADDR_STATUS_CLR: regRsp_r.data <= {8'h0, status_r}; // RULE_19
          `AED_ADDR_WAVE:       regRsp_r.data <= waveSample_r;
          default:              regRsp_r.data <= 24'h000000;
        endcase
      end
    end
  end

endmodule

// >>> verification/aed_datapath_chk.sv
// Concurrent checks on the ports of the energy datapath.
`timescale 1ns/1ps
`include "aed_consts.svh"
module aed_datapath_chk #(
  parameter int unsigned WAVE_BASE_CYC = 16
) (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic signed [23:0]    currentSample,
  input wire logic signed [23:0]    voltageSample,
  input wire aed_pkg::aed_reg_req_s regReq,
  input wire aed_pkg::aed_reg_rsp_s regRsp_r,
  input wire logic [23:0]           waveSample_r,
  input wire logic                  waveStrobe_r,
  input wire logic                  irqN_r
);
  import aed_pkg::*;
  logic [15:0] gapCnt_r;  // Clocks since the last waveform strobe.
  logic        seen_r;    // A first strobe has been seen, so the gap means something.
  wire clrRd = regReq.rd && regReq.addr == `AED_ADDR_STATUS_CLR;
  // Writing the enables may mask a pending flag, which lawfully releases the line.
  wire enWr = regReq.wr && regReq.addr == `AED_ADDR_IRQ_EN;
  // The gap counter restarts on each strobe; it may wrap when strobes stop, which is harmless.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      gapCnt_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      gapCnt_r <= waveStrobe_r ? 16'h0001 : gapCnt_r + 16'h0001;
      seen_r <= seen_r | waveStrobe_r;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_read_answer: assert property (regReq.rd |=> regRsp_r.valid)
    else $error("read answer missing");
  a_answer_cause: assert property (regRsp_r.valid |-> $past(regReq.rd))
    else $error("read answer without read");
  a_data_stands: assert property (!regRsp_r.valid |-> $stable(regRsp_r.data))
    else $error("read data moved without answer");
  a_unmapped_zero: assert property ((regReq.rd && (regReq.addr == 6'h00 ||
    regReq.addr > `AED_ADDR_WAVE)) |=> regRsp_r.data == 24'h000000)
    else $error("unmapped read not zero");
  a_strobe_pulse: assert property (waveStrobe_r |=> !waveStrobe_r)
    else $error("strobe longer than one cycle");
  a_strobe_gap: assert property (waveStrobe_r && seen_r |-> gapCnt_r >= WAVE_BASE_CYC)
    else $error("strobes too close");
  a_sample_hold: assert property (!waveStrobe_r |-> $stable(waveSample_r))
    else $error("wave sample moved without strobe");
  a_strobe_irq: assert property (waveStrobe_r |-> ##[0:1] !irqN_r)
    else $error("sample strobe without interrupt");
  a_irq_holds: assert property (!irqN_r && !clrRd && !enWr |=> !irqN_r)
    else $error("interrupt released without clear");
  a_irq_clear: assert property (clrRd && !waveStrobe_r ##1 !waveStrobe_r |-> irqN_r)
    else $error("interrupt not released by clear");
  c_strobe: cover property (waveStrobe_r);
  c_clear_read: cover property (regReq.rd && regReq.addr == `AED_ADDR_ENERGY_CLR);
  c_irq_release: cover property ($rose(irqN_r));
endmodule
bind aed_datapath aed_datapath_chk #(.WAVE_BASE_CYC(WAVE_BASE_CYC)) u_aed_datapath_chk (.clk,
  .resetn, .currentSample, .voltageSample, .regReq, .regRsp_r, .waveSample_r, .waveStrobe_r,
  .irqN_r);

// >>> verification/aed_host_model.sv
// Host controller model that issues register accesses to the datapath.
`timescale 1ns/1ps
`include "aed_consts.svh"
module aed_host_model (
  output aed_pkg::aed_reg_req_s      regReq,
  input  wire logic                  clk,
  input  wire aed_pkg::aed_reg_rsp_s regRsp
);
  import aed_pkg::*;
  initial regReq = '0;
  // Address and data are inverted when idle so a stale value is never mistaken for a live one.
  task automatic writeReg(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk);
    regReq.wr <= 1'b1;
    regReq.addr <= a;
    regReq.wdata <= d;
    @(posedge clk);
    regReq.wr <= 1'b0;
    regReq.addr <= ~a;
    regReq.wdata <= ~d;
  endtask
  // The answer is awaited for a few clocks only; ok stays low if it never comes.
  task automatic readReg(input logic [5:0] a, output logic [23:0] d, output logic ok);
    @(posedge clk);
    regReq.rd <= 1'b1;
    regReq.addr <= a;
    @(posedge clk);
    regReq.rd <= 1'b0;
    regReq.addr <= ~a;
    ok = 1'b0;
    d = 24'h000000;
    // The answer stands for one cycle only, so it is taken at the edge that closes that cycle.
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (regRsp.valid === 1'b1) begin
        ok = 1'b1;
        d = regRsp.data;
      end
    end
  endtask
  // Selects the waveform source and rate, then the sample interrupt enable.
  task automatic setWave(input logic [1:0] src, input logic [1:0] rate, input logic en);
    writeReg(`AED_ADDR_MODE, {9'h000, src, rate, 11'h000});
    writeReg(`AED_ADDR_IRQ_EN, {20'h00000, en, 3'h0});
  endtask
endmodule

// >>> verification/aed_datapath_tb.sv
// Self-checking testbench for the energy datapath.
`timescale 1ns/1ps
`include "aed_consts.svh"
module aed_datapath_tb;
  import aed_pkg::*;
  localparam int unsigned WB = 16;  // Short waveform base period to keep the run brief.
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  logic signed [23:0] currentSample = 24'sh000000;
  logic signed [23:0] voltageSample = 24'sh000000;
  aed_reg_req_s       regReq;
  aed_reg_rsp_s       regRsp;
  logic [23:0]        waveSample;
  logic               waveStrobe;
  logic               irqN;
  int                 fails = 0;
  int                 samplesChecked = 0;
  always #4 clk = ~clk;
  aed_datapath #(.WAVE_BASE_CYC(WB)) u_aed_datapath (.clk, .resetn, .currentSample,
    .voltageSample, .regReq, .regRsp_r(regRsp), .waveSample_r(waveSample),
    .waveStrobe_r(waveStrobe), .irqN_r(irqN));
  aed_host_model u_aed_host_model (.clk, .regReq, .regRsp);
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    logic ok;
    u_aed_host_model.readReg(a, d, ok);
    if (!ok) begin
      fails++;
      stopTest();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    u_aed_host_model.writeReg(a, d);
  endtask
  // Reset values, unmapped reads and stored widths, with the read-only energy written first.
  task automatic testRegs();
    logic [23:0] d;
    logic [5:0]  ta [9] = '{6'h05, 6'h01, 6'h01, 6'h01, 6'h02, 6'h02, 6'h02, 6'h03, 6'h04};
    logic [23:0] tw [9] = '{24'h123456, 24'h1f, 24'h21, 24'h20, 24'h7ff, 24'h800, 24'hfffff,
                            24'hffffff, 24'hff};
    logic [23:0] te [9] = '{24'h0, 24'h1f, 24'h21, 24'h21, 24'h7ff, 24'h800, 24'hfff,
                            24'hffff, 24'hff};
    for (int i = 1; i <= 13; i++) begin
      rd((i == 13) ? 6'h3f : 6'(i), d);
      check(d, (i == 1) ? 24'h00000d : 24'h000000);
    end
    for (int i = 0; i < 9; i++) begin
      wr(ta[i], tw[i]);
      rd(ta[i], d);
      check(d, te[i]);
    end
    wr(`AED_ADDR_GAIN, 24'h0);
    wr(`AED_ADDR_OFFSET, 24'h0);
    wr(`AED_ADDR_DIVIDER, 24'h0);
    // The negative offset above fed a few ticks into the accumulator; drop that residue.
    rd(`AED_ADDR_ENERGY_CLR, d);
  endtask
  // Energy change over a fixed time with only the offset feeding the accumulator.
  task automatic slope(input logic [15:0] ofs, input logic [7:0] dv, input int cyc,
                       input int lo, input int hi);
    logic [23:0] a;
    logic [23:0] b;
    int          dl;
    wr(`AED_ADDR_OFFSET, {8'h00, ofs});
    wr(`AED_ADDR_DIVIDER, {16'h0000, dv});
    rd(`AED_ADDR_ENERGY, a);
    repeat (cyc) @(posedge clk);
    rd(`AED_ADDR_ENERGY, b);
    dl = int'($signed(b - a));
    check({23'h0, dl >= lo && dl <= hi}, 24'h000001);
  endtask
  task automatic testEnergy();
    logic [23:0] a;
    logic [23:0] b;
    rd(`AED_ADDR_ENERGY, a);
    rd(`AED_ADDR_ENERGY, b);
    check(b, 24'h000000);
    slope(16'h7fff, 8'h00, 8192, 3, 4);
    slope(16'h7fff, 8'h02, 16384, 3, 4);
    slope(16'h8001, 8'h00, 8192, -4, -3);
    wr(`AED_ADDR_OFFSET, 24'h0);
    repeat (8) @(posedge clk);
    rd(`AED_ADDR_ENERGY, a);
    rd(`AED_ADDR_ENERGY, b);
    check(b, a);
    rd(`AED_ADDR_ENERGY_CLR, b);
    check(b, a);
    rd(`AED_ADDR_ENERGY, b);
    check(b, 24'h000000);
  endtask
  task automatic waitStrobe(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (waveStrobe !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      fails++;
      stopTest();
    end
  endtask
  // Strobe spacing at every rate, sample value, interrupt hold and release, refused source 01 and cleared enable.
  task automatic testWave();
    int          n;
    logic [23:0] d;
    wr(`AED_ADDR_OFFSET, 24'h001234);
    for (int r = 0; r < 4; r++) begin
      u_aed_host_model.setWave(2'b00, 2'(r), 1'b1);
      waitStrobe(n);
      waitStrobe(n);
      check(24'(n), 24'(WB << r));
      check(waveSample, 24'h000012);
      @(posedge clk);
      #1;
      check({23'h0, irqN}, 24'h0);
      rd(`AED_ADDR_STATUS, d);
      check(d & 24'h8, 24'h8);
      check({23'h0, irqN}, 24'h0);
      rd(`AED_ADDR_STATUS_CLR, d);
      check({23'h0, irqN}, 24'h1);
    end
    wr(`AED_ADDR_OFFSET, 24'h00ff00);
    waitStrobe(n);
    waitStrobe(n);
    check(waveSample, 24'hffffff);
    for (int k = 0; k < 2; k++) begin
      u_aed_host_model.setWave(k == 0 ? 2'b01 : 2'b00, 2'b00, k == 0);
      rd(`AED_ADDR_STATUS_CLR, d);
      n = 0;
      repeat (200) begin
        @(posedge clk);
        #1;
        n += int'(waveStrobe === 1'b1);
      end
      check(24'(n), 24'h0);
    end
  endtask
  // The run after the first reset flushes the delay lines with zero samples; the second reset clears the filter.
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (18000) @(posedge clk);
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    testRegs();
    testEnergy();
    testWave();
    stopTest();
  end
  initial begin
    #(8 * 100000);
    fails++;
    stopTest();
  end
endmodule
